/* File: rtl/host_bus_port.sv */
// host bus port with transmit page buffer and communication modes
`timescale 1ns/100ps
`include "host_port_defs.svh"
module host_bus_port (
   input  wire logic                     i_clk,
   input  wire logic                     i_srst,
   input  wire logic                     i_bus_style_select,
   input  wire logic                     i_addr_data_mux_select,
   input  wire logic                     i_strobe_polarity_invert,
   input  wire logic                     i_wide_bus_pin,
   input  wire logic [15:0]              i_data,
   input  wire logic [5:0]               i_addr,
   input  wire logic                     i_write_strobe_n,
   input  wire logic                     i_read_strobe_n,
   output logic      [15:0]              o_data,
   output logic                          o_data_oe,
   input  wire logic                     i_token_own,
   input  wire logic                     i_tx_done,
   input  wire logic [4:0]               i_link_rd_addr,
   output logic      [7:0]               o_link_rd_data,
   output logic                          o_tx_req,
   output host_port_pkg::tx_hdr_t        o_tx_hdr,
   output logic                          o_tx_active,
   output logic                          o_tx_comm_mode,
   output logic      [31:0]              o_rx_page_mode
);

   logic [`SYNC_W-1:0]         sync;
   logic                       style;
   logic                       mux;
   logic                       inv;
   logic                       wide;
   logic                       ds_act;
   logic                       latch_act;
   host_port_pkg::host_acc_t   acc;
   logic [5:0]                 latch_addr;
   logic                       wr_prev;
   logic                       rd_prev;
   logic [5:0]                 wr_addr;
   logic [15:0]                wr_data;
   logic                       wr_done;
   logic                       rd_start;
   logic [2:0]                 mode;
   logic [31:0]                rxm;
   logic [4:0]                 ptr;
   logic [7:0]                 page [`PAGE_BYTES];
   logic [7:0]                 wr_hold;
   logic                       wr_hold_v;
   logic [7:0]                 rd_hold;
   logic [15:0]                next_rdata;
   logic                       tx_avail;
   logic                       tx_cmd;
   host_port_pkg::tx_state_t   tx_state;

   // ***************************************
   // decoding shared by reads and writes
   // ***************************************
   function automatic logic is_reg(input logic [5:0] a,
                                   input logic [5:0] ofs);
      is_reg = (a[5:1] == ofs[5:1]);
   endfunction : is_reg

   function automatic logic [4:0] even(input logic [4:0] p);
      even = {p[4:1], 1'b0};
   endfunction : even

   // ***************************************
   // pin synchronisation
   // ***************************************
   pin_sync #(
      .W       (`SYNC_W)
   ) u_sync (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_pin   ({i_bus_style_select, i_addr_data_mux_select,
                 i_strobe_polarity_invert, i_wide_bus_pin,
                 i_write_strobe_n, i_read_strobe_n, i_addr, i_data}),
      .o_level (sync)
   );

   assign style = sync[27];
   assign mux   = sync[26];
   assign inv   = sync[25];
   assign wide  = sync[24];

   // ***************************************
   // strobe and address decode
   // ***************************************
   always_comb begin
      ds_act    = inv ? ~sync[22] : sync[22];
      latch_act = sync[19] ? sync[18] : ~sync[18];
      acc.data  = sync[15:0];
      acc.addr  = mux ? sync[21:16] : latch_addr;
      if (style) begin
         acc.rd = ds_act & sync[23];
         acc.wr = ds_act & ~sync[23];
      end else begin
         acc.rd = ~sync[22];
         acc.wr = ~sync[23];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         latch_addr <= 6'h00;
      end else if (!mux && latch_act) begin
         latch_addr <= sync[5:0];
      end
   end

   // ***************************************
   // access edges: write commits at the trailing edge
   // ***************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_prev <= 1'b0;
         rd_prev <= 1'b0;
         wr_addr <= 6'h00;
         wr_data <= 16'h0000;
      end else begin
         wr_prev <= acc.wr;
         rd_prev <= acc.rd;
         if (acc.wr) begin
            wr_addr <= acc.addr;
            wr_data <= acc.data;
         end
      end
   end

   assign wr_done  = wr_prev & ~acc.wr;
   assign rd_start = acc.rd & ~rd_prev;
   assign tx_cmd   = wr_done & is_reg(wr_addr, `OFS_CMD)
                     & wr_data[`CMD_TX];

   // ***************************************
   // mode and receive mode registers
   // ***************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mode <= `MODE_RST;
         rxm  <= `RXM_RST;
      end else if (wr_done) begin
         if (is_reg(wr_addr, `OFS_MODE)) begin
            mode <= wr_data[2:0];
         end
         for (int i = 0; i < `RXM_REGS; i++) begin
            if (is_reg(wr_addr, `OFS_RXM + 6'(2 * i))) begin
               rxm[8*i +: 8] <= wr_data[7:0];
            end
         end
         rxm[0] <= 1'b0;
      end
   end

   assign o_tx_comm_mode = mode[`MODE_REMOTE];
   assign o_rx_page_mode = rxm;

   // ***************************************
   // page pointer and word pairing
   // ***************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ptr       <= 5'h00;
         wr_hold   <= 8'h00;
         wr_hold_v <= 1'b0;
         rd_hold   <= 8'h00;
      end else if (wr_done && is_reg(wr_addr, `OFS_PTR)) begin
         ptr       <= wr_data[4:0];
         wr_hold_v <= 1'b0;
      end else if (wr_done && is_reg(wr_addr, `OFS_DATA)) begin
         if (wide) begin
            ptr <= even(ptr) + 5'h02;
         end else if (mode[`MODE_WORD]) begin
            if (!wr_addr[0]) begin
               wr_hold   <= wr_data[7:0];
               wr_hold_v <= 1'b1;
            end else if (wr_hold_v) begin
               wr_hold_v <= 1'b0;
               ptr       <= even(ptr) + 5'h02;
            end
         end else begin
            ptr <= ptr + 5'h01;
         end
      end else if (rd_start && is_reg(acc.addr, `OFS_DATA)) begin
         if (wide) begin
            ptr <= even(ptr) + 5'h02;
         end else if (mode[`MODE_WORD]) begin
            if (!acc.addr[0]) begin
               rd_hold <= page[even(ptr) | 5'h01];
            end else begin
               ptr <= even(ptr) + 5'h02;
            end
         end else begin
            ptr <= ptr + 5'h01;
         end
      end
   end

   // ***************************************
   // transmit page storage
   // ***************************************
   always_ff @(posedge i_clk) begin
      if (wr_done && is_reg(wr_addr, `OFS_DATA)) begin
         if (wide) begin
            page[even(ptr)]         <= wr_data[7:0];
            page[even(ptr) | 5'h01] <= wr_data[15:8];
         end else if (mode[`MODE_WORD]) begin
            if (wr_addr[0] && wr_hold_v) begin
               page[even(ptr)]         <= wr_hold;
               page[even(ptr) | 5'h01] <= wr_data[7:0];
            end
         end else begin
            page[ptr] <= wr_data[7:0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_link_rd_data <= 8'h00;
      end else begin
         o_link_rd_data <= page[i_link_rd_addr];
      end
   end

   // ***************************************
   // read data; odd pointer upper byte passes as stored
   // ***************************************
   always_comb begin
      next_rdata = 16'h0000;
      if (is_reg(acc.addr, `OFS_MODE)) begin
         next_rdata = {13'h0000, mode};
      end else if (is_reg(acc.addr, `OFS_STAT)) begin
         next_rdata = {14'h0000, o_tx_active, tx_avail};
      end else if (is_reg(acc.addr, `OFS_PTR)) begin
         next_rdata = {11'h000, ptr};
      end else if (is_reg(acc.addr, `OFS_DATA)) begin
         if (wide) begin
            next_rdata = {page[even(ptr) | 5'h01], page[even(ptr)]};
         end else if (mode[`MODE_WORD]) begin
            next_rdata = {8'h00, acc.addr[0] ? rd_hold
                                             : page[even(ptr)]};
         end else begin
            next_rdata = {8'h00, page[ptr]};
         end
      end else begin
         for (int i = 0; i < `RXM_REGS; i++) begin
            if (is_reg(acc.addr, `OFS_RXM + 6'(2 * i))) begin
               next_rdata = {8'h00, rxm[8*i +: 8]};
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_data    <= 16'h0000;
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= acc.rd;
         if (rd_start) begin
            o_data <= next_rdata;
         end
      end
   end

   // ***************************************
   // transmit sequencing
   // ***************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         tx_state    <= host_port_pkg::TX_IDLE;
         tx_avail    <= 1'b1;
         o_tx_active <= 1'b0;
         o_tx_req    <= 1'b0;
         o_tx_hdr    <= '0;
      end else begin
         o_tx_req <= 1'b0;
         case (tx_state)
            host_port_pkg::TX_IDLE: begin
               if (tx_cmd) begin
                  tx_state    <= host_port_pkg::TX_WAIT;
                  tx_avail    <= 1'b0;
                  o_tx_active <= 1'b1;
               end
            end
            host_port_pkg::TX_WAIT: begin
               if (i_token_own) begin
                  tx_state                    <= host_port_pkg::TX_SEND;
                  o_tx_req                    <= 1'b1;
                  o_tx_hdr.source_node_id     <= page[`HDR_SRC];
                  o_tx_hdr.dest_node_id       <= page[`HDR_DST];
                  o_tx_hdr.data_start_pointer <= page[`HDR_PTR];
                  o_tx_hdr.broadcast <= (page[`HDR_DST] == 8'h00);
               end
            end
            host_port_pkg::TX_SEND: begin
               if (i_tx_done) begin
                  if ((mode[`MODE_REMOTE] && !mode[`MODE_SSHOT])
                      || tx_cmd) begin
                     tx_state <= host_port_pkg::TX_WAIT;
                  end else begin
                     tx_state    <= host_port_pkg::TX_IDLE;
                     tx_avail    <= 1'b1;
                     o_tx_active <= 1'b0;
                  end
               end
            end
            default: begin
               tx_state    <= host_port_pkg::TX_IDLE;
               tx_avail    <= 1'b1;
               o_tx_active <= 1'b0;
            end
         endcase
      end
   end

endmodule : host_bus_port

/* File: rtl/host_port_defs.svh */
// constants for the host bus port: offsets, field positions, reset values
//
// Contract
// - style pin selects strobe pair or direction mode
// - mux select low multiplexes address on data pins
// - strobe polarity invert pin sets data strobe level
// - odd pointer gives invalid upper byte, host discards
// - no sending without a host command
// - one transmit mode bit, per-page receive mode bits
// - free-format sends on next own token
// - free-format sends only on command, any layout
// - remote-buffer sends transmit page on every token
// - single-shot sends one packet per command
// - single-shot set mid-run stops after current packet
// - wide access keeps both word bytes together
// - zero destination marks broadcast
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ***************************************
// register offsets on the host address pins
// ***************************************
`define OFS_MODE      6'h00
`define OFS_CMD       6'h02
`define OFS_STAT      6'h04
`define OFS_PTR       6'h06
`define OFS_DATA      6'h08
`define OFS_RXM       6'h0A
`define RXM_REGS      4

// ***************************************
// field positions and reset values
// ***************************************
`define MODE_REMOTE   0
`define MODE_SSHOT    1
`define MODE_WORD     2
`define CMD_TX        0
`define MODE_RST      3'h0
`define RXM_RST       32'h0000_0000

// ***************************************
// page layout
// ***************************************
`define PAGE_BYTES    32
`define PAGE_AW       5
`define HDR_SRC       5'h00
`define HDR_DST       5'h01
`define HDR_PTR       5'h02
`define SYNC_W        28

`endif

/* File: rtl/host_port_pkg.sv */
// types for the host bus port
package host_port_pkg;

   // ***************************************
   // transmit header handed to the link
   // ***************************************
   typedef struct packed {
      logic       broadcast;
      logic [7:0] source_node_id;
      logic [7:0] dest_node_id;
      logic [7:0] data_start_pointer;
   } tx_hdr_t;

   // ***************************************
   // decoded host access
   // ***************************************
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [5:0]  addr;
      logic [15:0] data;
   } host_acc_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SEND = 2'b10
   } tx_state_t;

endpackage : host_port_pkg

/* File: rtl/pin_sync.sv */
// three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge i_clk) begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
   end

   // ***************************************
   // per-bit acceptance
   // ***************************************
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               o_level[g] <= 1'b1;
            end else if (stage2[g] == stage3[g]) begin
               o_level[g] <= stage3[g];
            end
         end
      end
   endgenerate

endmodule : pin_sync

/* File: verif/host_cpu_model.sv */
// host processor bus model driving the port's host pins
`timescale 1ns/100ps
module host_cpu_model (
   input  wire logic        i_clk,
   input  wire logic        i_style,
   input  wire logic        i_mux,
   input  wire logic        i_inv,
   input  wire logic [15:0] i_rdata,
   output logic      [15:0] o_data,
   output logic      [5:0]  o_addr,
   output logic             o_wr_n,
   output logic             o_rd_n
);
   // ********
   // idle pins and one access
   // ********
   initial begin
      o_data = 16'h0000;
      o_addr = 6'h00;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
   end

   task automatic park(input logic s, input logic inv);
      o_wr_n <= 1'b1;
      o_rd_n <= s ? inv : 1'b1;
   endtask : park

   // one strobe line, already the or of both byte strobes
   task automatic acc(input logic w, input logic [5:0] a,
                      input logic [15:0] d, output logic [15:0] q);
      if (!i_mux) begin
         o_data <= {~o_data[15:6], a};
         o_addr <= {2'b00, i_inv, i_inv, 2'b00};
         repeat (8) @(posedge i_clk);
         o_addr <= {2'b00, i_inv, !i_inv, 2'b00};
         repeat (2) @(posedge i_clk);
      end else begin
         o_addr <= a;
      end
      o_data <= w ? d : ~o_data;
      if (i_style) begin
         o_wr_n <= !w;
         o_rd_n <= !i_inv;
      end else if (w) begin
         o_wr_n <= 1'b0;
      end else begin
         o_rd_n <= 1'b0;
      end
      repeat (8) @(posedge i_clk);
      q = i_rdata;
      park(i_style, i_inv);
      o_data <= ~o_data;
      repeat (8) @(posedge i_clk);
   endtask : acc
endmodule : host_cpu_model

/* File: verif/host_bus_port_checker.sv */
// assertions on the host bus port
`timescale 1ns/100ps
module host_bus_port_checker (
   input wire logic                   i_clk,
   input wire logic                   i_srst,
   input wire logic                   i_bus_style_select,
   input wire logic                   i_strobe_polarity_invert,
   input wire logic                   i_write_strobe_n,
   input wire logic                   i_read_strobe_n,
   input wire logic                   i_token_own,
   input wire logic                   i_tx_done,
   input wire logic                   o_data_oe,
   input wire logic                   o_tx_req,
   input wire host_port_pkg::tx_hdr_t o_tx_hdr,
   input wire logic                   o_tx_active,
   input wire logic [31:0]            o_rx_page_mode
);
   logic rd_act;
   assign rd_act = i_bus_style_select ?
      (i_write_strobe_n && (i_read_strobe_n ^ i_strobe_polarity_invert)) :
      !i_read_strobe_n;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   req_pulse_a: assert property (o_tx_req |=> !o_tx_req)
      else $error("transmit request longer than one cycle");
   req_token_a: assert property (o_tx_req |-> $past(i_token_own))
      else $error("transmit request without own token");
   req_armed_a: assert property (o_tx_req |-> o_tx_active)
      else $error("transmit request while not armed");
   bcast_flag_a: assert property (o_tx_req |->
      o_tx_hdr.broadcast == (o_tx_hdr.dest_node_id == 8'h00))
      else $error("broadcast flag wrong");
   hdr_hold_a: assert property (!o_tx_req |-> $stable(o_tx_hdr))
      else $error("header changed without request");
   rx_page0_a: assert property (o_rx_page_mode[0] == 1'b0)
      else $error("page zero receive bit set");
   oe_cause_a: assert property ($rose(o_data_oe) |-> $past(rd_act, 2))
      else $error("read enable without read strobe");
   oe_drop_a: assert property ($fell(rd_act) |-> ##[1:6] !o_data_oe)
      else $error("read enable stuck after strobe");
   act_end_a: assert property ($fell(o_tx_active) |-> $past(i_tx_done))
      else $error("transmit stopped before packet end");
endmodule : host_bus_port_checker

bind host_bus_port host_bus_port_checker host_bus_port_checker_inst (
   .i_clk                    (i_clk),
   .i_srst                   (i_srst),
   .i_bus_style_select       (i_bus_style_select),
   .i_strobe_polarity_invert (i_strobe_polarity_invert),
   .i_write_strobe_n         (i_write_strobe_n),
   .i_read_strobe_n          (i_read_strobe_n),
   .i_token_own              (i_token_own),
   .i_tx_done                (i_tx_done),
   .o_data_oe                (o_data_oe),
   .o_tx_req                 (o_tx_req),
   .o_tx_hdr                 (o_tx_hdr),
   .o_tx_active              (o_tx_active),
   .o_rx_page_mode           (o_rx_page_mode)
);

/* File: verif/tb_top.sv */
// self-checking bench for the host bus port
`timescale 1ns/100ps
`include "host_port_defs.svh"
module tb_top;
   logic                   i_clk = 1'b0;
   logic                   i_srst = 1'b1;
   logic                   style = 1'b0, mux = 1'b1, inv = 1'b1;
   logic                   wide = 1'b0, tok = 1'b0, done = 1'b0;
   logic [4:0]             lra = 5'h00;
   logic [15:0]            hd, rdat, q;
   logic [5:0]             ha;
   logic                   wr_n, rd_n, oe, req, act, tmode;
   logic [7:0]             lrd;
   logic [31:0]            rxm, exp_rxm, m;
   logic [31:0]            lfsr = 32'h71D61230;
   logic [3:0]             cfgs [4] = '{4'h6, 4'h2, 4'hE, 4'h8};
   logic [7:0]             page [32];
   host_port_pkg::tx_hdr_t hdr;
   int                     fail_count = 0, check_count = 0;

   host_bus_port host_bus_port_inst (.i_clk(i_clk), .i_srst(i_srst),
      .i_bus_style_select(style), .i_addr_data_mux_select(mux),
      .i_strobe_polarity_invert(inv), .i_wide_bus_pin(wide), .i_data(hd),
      .i_addr(ha), .i_write_strobe_n(wr_n), .i_read_strobe_n(rd_n),
      .o_data(rdat), .o_data_oe(oe), .i_token_own(tok), .i_tx_done(done),
      .i_link_rd_addr(lra), .o_link_rd_data(lrd), .o_tx_req(req),
      .o_tx_hdr(hdr), .o_tx_active(act), .o_tx_comm_mode(tmode),
      .o_rx_page_mode(rxm));
   host_cpu_model host_cpu_model_inst (.i_clk(i_clk), .i_style(style),
      .i_mux(mux), .i_inv(inv), .i_rdata(rdat), .o_data(hd), .o_addr(ha),
      .o_wr_n(wr_n), .o_rd_n(rd_n));

   // ********
   // helpers
   // ********
   initial forever #20 i_clk = ~i_clk;
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      host_cpu_model_inst.acc(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      host_cpu_model_inst.acc(1'b0, a, 16'h0000, q);
      chk(32'(q), 32'(e));
   endtask : rd
   task automatic lchk(input int a);
      lra <= a[4:0];
      cyc(2);
      chk(32'(lrd), 32'(page[a]));
   endtask : lchk
   task automatic setup(input logic [3:0] c, input logic r);
      {style, mux, inv, wide} <= c;
      host_cpu_model_inst.park(c[3], c[1]);
      i_srst <= r;
      cyc(10);
      i_srst <= 1'b0;
      cyc(4);
   endtask : setup
   task automatic pulse_tok(input logic e);
      tok <= 1'b1;
      cyc(1);
      tok <= 1'b0;
      @(negedge i_clk);
      chk(32'(req), 32'(e));
      if (e) chk(32'(hdr), {7'h00, page[1] == 8'h00, page[0], page[1],
                            page[2]});
      cyc(1);
   endtask : pulse_tok
   task automatic pulse_done(input logic e);
      done <= 1'b1;
      cyc(1);
      done <= 1'b0;
      cyc(3);
      chk(32'(act), 32'(e));
   endtask : pulse_done
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   // ********
   // tests
   // ********
   initial begin
      cyc(60000); // tests need well under a tenth of this
      fail_count++;
      results();
   end
   initial begin
      for (int c = 0; c < 4; c++) begin
         setup(cfgs[c], c != 3);
         rd(`OFS_STAT, 16'h0001);
         m = rnd();
         wr(`OFS_MODE, 16'(m[2:0]));
         rd(`OFS_MODE, 16'(m[2:0]));
         chk(32'(tmode), 32'(m[0]));
         for (int i = 0; i < 4; i++) begin
            m = rnd();
            exp_rxm[8*i +: 8] = m[7:0];
            wr(`OFS_RXM + 6'(2*i), 16'(m[7:0]));
         end
         exp_rxm[0] = 1'b0;
         wr(6'h3E, 16'hFFFF);
         rd(6'h3E, 16'h0000);
         chk(rxm, exp_rxm);
         $display("pin style %0d done", c);
      end
      setup(4'h7, 1'b1);
      wr(`OFS_PTR, 16'h0000);
      for (int i = 0; i < 32; i += 2) begin
         m = rnd();
         {page[i+1], page[i]} = m[15:0];
         wr(`OFS_DATA, m[15:0]);
      end
      for (int i = 0; i < 32; i++) lchk(i);
      wr(`OFS_PTR, 16'h0004);
      rd(`OFS_DATA, {page[5], page[4]});
      rd(`OFS_DATA, {page[7], page[6]});
      $display("wide bus done");
      setup(4'h6, 1'b1);
      wr(`OFS_MODE, 16'h0004);
      wr(`OFS_PTR, 16'h001A);
      for (int i = 26; i < 32; i += 2) begin
         m = rnd();
         {page[i+1], page[i]} = m[15:0];
         wr(`OFS_DATA, 16'(m[7:0]));
         wr(6'h09, 16'(m[15:8]));
      end
      wr(6'h09, 16'h00A5);
      for (int i = 26; i < 32; i++) lchk(i);
      lchk(0);
      lchk(1);
      wr(`OFS_PTR, 16'h001C);
      rd(`OFS_DATA, {8'h00, page[28]});
      rd(6'h09, {8'h00, page[29]});
      $display("word mode done");
      wr(`OFS_MODE, 16'h0000);
      wr(`OFS_PTR, 16'h0000);
      page[0] = 8'h11;
      page[1] = 8'h00;
      page[2] = 8'h1A;
      for (int i = 0; i < 3; i++) wr(`OFS_DATA, 16'(page[i]));
      lchk(2);
      wr(`OFS_PTR, 16'h0002);
      rd(`OFS_DATA, {8'h00, page[2]});
      pulse_tok(1'b0);
      wr(`OFS_CMD, 16'h0001);
      rd(`OFS_STAT, 16'h0002);
      pulse_tok(1'b1);
      pulse_done(1'b0);
      rd(`OFS_STAT, 16'h0001);
      pulse_tok(1'b0);
      $display("free format done");
      page[1] = 8'h05;
      wr(`OFS_PTR, 16'h0001);
      wr(`OFS_DATA, 16'h0005);
      wr(`OFS_MODE, 16'h0001);
      wr(`OFS_CMD, 16'h0001);
      for (int i = 0; i < 2; i++) begin
         pulse_tok(1'b1);
         pulse_done(1'b1);
      end
      pulse_tok(1'b1);
      wr(`OFS_MODE, 16'h0003);
      pulse_done(1'b0);
      pulse_tok(1'b0);
      wr(`OFS_CMD, 16'h0001);
      pulse_tok(1'b1);
      pulse_done(1'b0);
      pulse_tok(1'b0);
      $display("remote buffer done");
      results();
   end
endmodule : tb_top
